// ===== design/bcfm_params.svh
// Constants for the broadcast command decoder and fault code encoder.
// Assumes inclusion by bcfm_top only.
`ifndef BCFM_PARAMS_SVH
`define BCFM_PARAMS_SVH
// Broadcast register numbers and operation word layout
`define BCFM_REG_OP       16'h0001
`define BCFM_REG_FREQ     16'h0002
`define BCFM_BIT_RUN      0
`define BCFM_BIT_REV      1
`define BCFM_BIT_EXTF     4
`define BCFM_BIT_FRST     5
`define BCFM_BIT_DI5      12
`define BCFM_BIT_DI6      13
`define BCFM_BIT_DI7      14
`define BCFM_OP_MASK      16'h7033
`define BCFM_OP_RESET     16'h0000
`define BCFM_FREQ_FULL    32'h0000_7530
`define BCFM_PCT_FULL     32'h0000_2710
`define BCFM_HIST_DEPTH   4
// Fixed fault codes
`define BCFM_C_NONE       16'h0000
`define BCFM_C_DC_BUS_UV  16'h0002
`define BCFM_C_CTRL_UV    16'h0003
`define BCFM_C_SOFT_CHG   16'h0004
`define BCFM_C_SHORT      16'h0005
`define BCFM_C_GROUND     16'h0006
`define BCFM_C_OVERCUR    16'h0007
`define BCFM_C_OVERVOLT   16'h0008
`define BCFM_C_MOTOR_OL   16'h000b
`define BCFM_C_DRIVE_OL   16'h000c
`define BCFM_C_OVERTQ1    16'h000d
`define BCFM_C_OVERTQ2    16'h000e
`define BCFM_C_EXT_T3     16'h0011
`define BCFM_C_SERIAL_CE  16'h0021
`define BCFM_C_OPT_CE     16'h0022
`define BCFM_C_OPT_EXTF   16'h0027
`define BCFM_C_UNDERTQ1   16'h0029
`define BCFM_C_UNDERTQ2   16'h002a
`define BCFM_C_OPT_GRP    16'h0030
`define BCFM_C_EXT_T1     16'h0042
`define BCFM_C_EXT_T2     16'h0043
`define BCFM_C_CPF_BASE   16'h0081
`define BCFM_C_OPTA_BASE  16'h0101
`define BCFM_C_OPTB_BASE  16'h0111
`define BCFM_C_OPTC_BASE  16'h0131
`define BCFM_C_KP_TIME    16'h0401
`define BCFM_C_KP_BATT    16'h0402
`define BCFM_C_SAFETY     16'h040f
`define BCFM_C_CMP1       16'h0414
`define BCFM_C_CMP2       16'h0415
`define BCFM_C_COMM_E1    16'h041a
`define BCFM_C_COMM_E2    16'h041b
`define BCFM_C_OVERCUR2   16'h045f
`endif

// ===== design/bcfm_pkg.sv
// Types for the broadcast command decoder and fault code encoder.
// Assumes bcfm_params.svh is on the include path.
package bcfm_pkg;
  // Source group of a fault event
  typedef enum logic [1:0] {
    GRP_FIXED = 2'h0, GRP_CTRL = 2'h1, GRP_OPT = 2'h2
  } bcfm_grp_t;
  // Faults that carry a fixed code
  typedef enum logic [4:0] {
    FLT_DC_BUS_UV = 5'h00, FLT_CTRL_UV  = 5'h01, FLT_SOFT_CHG = 5'h02,
    FLT_SHORT     = 5'h03, FLT_GROUND   = 5'h04, FLT_OVERCUR  = 5'h05,
    FLT_OVERVOLT  = 5'h06, FLT_OVERCUR2 = 5'h07, FLT_MOTOR_OL = 5'h08,
    FLT_DRIVE_OL  = 5'h09, FLT_OVERTQ1  = 5'h0a, FLT_OVERTQ2  = 5'h0b,
    FLT_UNDERTQ1  = 5'h0c, FLT_UNDERTQ2 = 5'h0d, FLT_EXT_T3   = 5'h0e,
    FLT_EXT_T4    = 5'h0f, FLT_EXT_T5   = 5'h10, FLT_EXT_T6   = 5'h11,
    FLT_EXT_T7    = 5'h12, FLT_EXT_T1   = 5'h13, FLT_EXT_T2   = 5'h14,
    FLT_OPT_EXTF  = 5'h15, FLT_SERIAL_CE = 5'h16, FLT_OPT_CE  = 5'h17,
    FLT_COMM_E1   = 5'h18, FLT_COMM_E2  = 5'h19, FLT_KP_TIME  = 5'h1a,
    FLT_KP_BATT   = 5'h1b, FLT_SAFETY   = 5'h1c, FLT_CMP1     = 5'h1d,
    FLT_CMP2      = 5'h1e
  } bcfm_fault_t;
  // One broadcast register write from the protocol engine
  typedef struct packed {
    logic        valid;
    logic [15:0] reg_no;
    logic [15:0] data;
  } bcfm_bcast_t;
  // One detected fault; idx is the fixed id, error index or option number
  typedef struct packed {
    logic        valid;
    bcfm_grp_t   grp;
    logic [7:0]  idx;
  } bcfm_evt_t;
  // Decoded run commands
  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       ext_fault;
    logic [2:0] multi_function_digital_input;
  } bcfm_cmd_t;
endpackage : bcfm_pkg

// ===== design/bcfm_top.sv
// Broadcast operation/frequency decoder and fault trace/history encoder.
// Assumes bcast_i and fault_evt_i come from logic on clock_i.
// How it works
// - Broadcast registers are write-only data; no acknowledge is ever returned.
// - Undefined operation word bits take the local operation signal value.
// - Bit 0 of register 0001 is run (1) or stop (0).
// - Bit 1 selects reverse (1) or forward (0) rotation.
// - Bit 4 set raises the option card external fault.
// - Bit 5 set issues a fault reset command.
// - Bits C, D, E drive digital inputs five, six, seven.
// - Register 0002 is frequency reference, 30000 equals 100 percent.
// - Recorded faults are reported as 16-bit codes from a fixed table.
// - Undervoltage faults encode as 0002, 0003, 0004.
// - Power stage faults encode 0005 to 0008 and 045F.
// - Load faults encode 000B to 000E, 0029, 002A.
// - Terminal faults 3-7 encode 0011-0015, 1-2 as 0042-0043, option 0027.
// - Link faults encode 0021, 0022, 041A, 041B.
// - Option hardware and protocol faults also report collective code 0030.
// - Control circuit errors encode 0081 plus index, 0083 to 00A7.
// - Option hardware faults encode 0101 through 0118.
// - Option protocol faults encode 0131 through 013E.
// - Keypad and safety faults encode 0401, 0402, 040F, 0414, 0415.
`include "bcfm_params.svh"

module bcfm_top (
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire bcfm_pkg::bcfm_bcast_t bcast_i,
  input  wire logic [15:0]          local_op_i,
  input  wire bcfm_pkg::bcfm_evt_t  fault_evt_i,
  output bcfm_pkg::bcfm_cmd_t       cmd_o,
  output logic [15:0]               op_word_o,
  output logic                      fault_reset_o,
  output logic [15:0]               freq_ref_o,
  output logic [15:0]               freq_pct_o,
  output logic [15:0]               trace_code_o,
  output logic [15:0]               group_code_o,
  output logic [15:0]               hist_o [`BCFM_HIST_DEPTH]
);

  // ----------------------------------------------------------------
  // Fault code table
  // ----------------------------------------------------------------
  function automatic logic [15:0] code_of(bcfm_pkg::bcfm_evt_t e);
    logic [15:0] c;
    logic [15:0] n;
    c = `BCFM_C_NONE;
    n = {8'h00, e.idx};
    unique case (e.grp)
      bcfm_pkg::GRP_FIXED: begin
        case (bcfm_pkg::bcfm_fault_t'(e.idx[4:0]))
          bcfm_pkg::FLT_DC_BUS_UV: c = `BCFM_C_DC_BUS_UV;
          bcfm_pkg::FLT_CTRL_UV:   c = `BCFM_C_CTRL_UV;
          bcfm_pkg::FLT_SOFT_CHG:  c = `BCFM_C_SOFT_CHG;
          bcfm_pkg::FLT_SHORT:     c = `BCFM_C_SHORT;
          bcfm_pkg::FLT_GROUND:    c = `BCFM_C_GROUND;
          bcfm_pkg::FLT_OVERCUR:   c = `BCFM_C_OVERCUR;
          bcfm_pkg::FLT_OVERVOLT:  c = `BCFM_C_OVERVOLT;
          bcfm_pkg::FLT_OVERCUR2:  c = `BCFM_C_OVERCUR2;
          bcfm_pkg::FLT_MOTOR_OL:  c = `BCFM_C_MOTOR_OL;
          bcfm_pkg::FLT_DRIVE_OL:  c = `BCFM_C_DRIVE_OL;
          bcfm_pkg::FLT_OVERTQ1:   c = `BCFM_C_OVERTQ1;
          bcfm_pkg::FLT_OVERTQ2:   c = `BCFM_C_OVERTQ2;
          bcfm_pkg::FLT_UNDERTQ1:  c = `BCFM_C_UNDERTQ1;
          bcfm_pkg::FLT_UNDERTQ2:  c = `BCFM_C_UNDERTQ2;
          bcfm_pkg::FLT_EXT_T3,
          bcfm_pkg::FLT_EXT_T4,
          bcfm_pkg::FLT_EXT_T5,
          bcfm_pkg::FLT_EXT_T6,
          bcfm_pkg::FLT_EXT_T7:
            c = `BCFM_C_EXT_T3 + (n - 16'(bcfm_pkg::FLT_EXT_T3));
          bcfm_pkg::FLT_EXT_T1:    c = `BCFM_C_EXT_T1;
          bcfm_pkg::FLT_EXT_T2:    c = `BCFM_C_EXT_T2;
          bcfm_pkg::FLT_OPT_EXTF:  c = `BCFM_C_OPT_EXTF;
          bcfm_pkg::FLT_SERIAL_CE: c = `BCFM_C_SERIAL_CE;
          bcfm_pkg::FLT_OPT_CE:    c = `BCFM_C_OPT_CE;
          bcfm_pkg::FLT_COMM_E1:   c = `BCFM_C_COMM_E1;
          bcfm_pkg::FLT_COMM_E2:   c = `BCFM_C_COMM_E2;
          bcfm_pkg::FLT_KP_TIME:   c = `BCFM_C_KP_TIME;
          bcfm_pkg::FLT_KP_BATT:   c = `BCFM_C_KP_BATT;
          bcfm_pkg::FLT_SAFETY:    c = `BCFM_C_SAFETY;
          bcfm_pkg::FLT_CMP1:      c = `BCFM_C_CMP1;
          bcfm_pkg::FLT_CMP2:      c = `BCFM_C_CMP2;
          default:                 c = `BCFM_C_NONE;
        endcase
        // Fixed ids stop at 5 bits; wider values carry no code
        if (e.idx[7:5] != 3'h0) begin
          c = `BCFM_C_NONE;
        end
      end
      bcfm_pkg::GRP_CTRL: begin
        // Only the listed error indices have codes
        if (e.idx == 8'h02 || e.idx == 8'h03 || e.idx == 8'h06 ||
            e.idx == 8'h08 || (e.idx >= 8'h0b && e.idx <= 8'h0e) ||
            (e.idx >= 8'h10 && e.idx <= 8'h18) || e.idx == 8'h26) begin
          c = `BCFM_C_CPF_BASE + n;
        end
      end
      bcfm_pkg::GRP_OPT: begin
        // Option number counted in decimal, three code ranges
        if (e.idx <= 8'h01 || e.idx == 8'h05 || e.idx == 8'h06) begin
          c = `BCFM_C_OPTA_BASE + n;
        end else if (e.idx >= 8'h0a && e.idx <= 8'h11) begin
          c = `BCFM_C_OPTB_BASE + (n - 16'h000a);
        end else if (e.idx >= 8'h1e && e.idx <= 8'h2b) begin
          c = `BCFM_C_OPTC_BASE + (n - 16'h001e);
        end
      end
      default: c = `BCFM_C_NONE;
    endcase
    return c;
  endfunction : code_of

  // ----------------------------------------------------------------
  // Broadcast decode
  // ----------------------------------------------------------------
  logic        op_hit;
  logic        freq_hit;
  logic [15:0] bc_op_q;
  logic [15:0] bc_op_d;
  logic        seen_q;
  logic        seen_d;
  logic [15:0] op_q;
  logic [15:0] op_d;
  logic        frst_q;
  logic        frst_d;
  logic [15:0] freq_q;
  logic [15:0] freq_d;
  logic [15:0] pct_q;
  logic [15:0] pct_d;

  // Writes are absorbed silently, no answer path exists
  assign op_hit   = bcast_i.valid && bcast_i.reg_no == `BCFM_REG_OP;
  assign freq_hit = bcast_i.valid && bcast_i.reg_no == `BCFM_REG_FREQ;

  // Next held word, merged word, reset pulse, frequency
  always_comb begin
    bc_op_d = op_hit ? (bcast_i.data & `BCFM_OP_MASK) : bc_op_q;
    seen_d  = seen_q | op_hit;
    if (seen_d) begin
      op_d = bc_op_d | (local_op_i & ~`BCFM_OP_MASK);
    end else begin
      op_d = local_op_i;
    end
    frst_d = op_hit && bcast_i.data[`BCFM_BIT_FRST];
    freq_d = freq_hit ? bcast_i.data : freq_q;
    pct_d  = 16'((32'(freq_d) * `BCFM_PCT_FULL) / `BCFM_FREQ_FULL);
  end

  // Broadcast state registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bc_op_q <= `BCFM_OP_RESET;
      seen_q  <= 1'b0;
      op_q    <= `BCFM_OP_RESET;
      frst_q  <= 1'b0;
      freq_q  <= 16'h0000;
      pct_q   <= 16'h0000;
    end else begin
      bc_op_q <= bc_op_d;
      seen_q  <= seen_d;
      op_q    <= op_d;
      frst_q  <= frst_d;
      freq_q  <= freq_d;
      pct_q   <= pct_d;
    end
  end

  // Command fields from the merged word
  assign cmd_o.run       = op_q[`BCFM_BIT_RUN];
  assign cmd_o.reverse   = op_q[`BCFM_BIT_REV];
  assign cmd_o.ext_fault = op_q[`BCFM_BIT_EXTF];
  assign cmd_o.multi_function_digital_input      = {op_q[`BCFM_BIT_DI7], op_q[`BCFM_BIT_DI6],
                            op_q[`BCFM_BIT_DI5]};
  assign op_word_o       = op_q;
  assign fault_reset_o   = frst_q;
  assign freq_ref_o      = freq_q;
  assign freq_pct_o      = pct_q;

  // ----------------------------------------------------------------
  // Fault trace and history
  // ----------------------------------------------------------------
  logic [15:0] new_code;
  logic        rec;
  logic [15:0] trace_q;
  logic [15:0] trace_d;
  logic [15:0] grp_q;
  logic [15:0] grp_d;
  logic [15:0] hist_q [`BCFM_HIST_DEPTH];
  logic [15:0] hist_d [`BCFM_HIST_DEPTH];

  assign new_code = code_of(fault_evt_i);
  assign rec      = fault_evt_i.valid && new_code != `BCFM_C_NONE;

  // New fault wins over a same-cycle reset clear
  always_comb begin
    trace_d = trace_q;
    grp_d   = grp_q;
    hist_d  = hist_q;
    if (rec) begin
      trace_d = new_code;
      grp_d = (fault_evt_i.grp == bcfm_pkg::GRP_OPT) ?
              `BCFM_C_OPT_GRP : `BCFM_C_NONE;
      hist_d[0] = new_code;
      for (int i = 1; i < `BCFM_HIST_DEPTH; i++) begin
        hist_d[i] = hist_q[i-1];
      end
    end else if (frst_q) begin
      trace_d = `BCFM_C_NONE;
      grp_d   = `BCFM_C_NONE;
    end
  end

  // Trace and history registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trace_q <= `BCFM_C_NONE;
      grp_q   <= `BCFM_C_NONE;
      for (int i = 0; i < `BCFM_HIST_DEPTH; i++) begin
        hist_q[i] <= `BCFM_C_NONE;
      end
    end else begin
      trace_q <= trace_d;
      grp_q   <= grp_d;
      hist_q  <= hist_d;
    end
  end

  assign trace_code_o = trace_q;
  assign group_code_o = grp_q;
  assign hist_o       = hist_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  run_follows_a: assert property (op_hit |=>
    cmd_o.run == $past(bcast_i.data[0]))
    else $error("run does not follow broadcast bit 0");
  dir_follows_a: assert property (op_hit |=>
    cmd_o.reverse == $past(bcast_i.data[1]))
    else $error("direction does not follow bit 1");
  extf_follows_a: assert property (op_hit |=>
    cmd_o.ext_fault == $past(bcast_i.data[4]))
    else $error("external fault does not follow bit 4");
  reset_pulse_a: assert property (op_hit && bcast_i.data[5] |=>
    fault_reset_o ##1 (!fault_reset_o || $past(op_hit)))
    else $error("fault reset pulse wrong");
  inputs_map_a: assert property (op_hit |=>
    cmd_o.multi_function_digital_input == $past(bcast_i.data[14:12]))
    else $error("digital inputs do not follow bits C-E");
  local_bits_a: assert property (seen_q |=>
    (op_word_o & 16'h8fcc) == ($past(local_op_i) & 16'h8fcc))
    else $error("undefined bits not taken from local word");
  freq_scale_a: assert property (freq_hit && bcast_i.data == 16'h7530
    |=> freq_pct_o == 16'h2710)
    else $error("full scale frequency not 100 percent");
  uv_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_FIXED && fault_evt_i.idx == 8'h00
    |=> trace_code_o == 16'h0002 && hist_o[0] == 16'h0002)
    else $error("dc bus undervoltage code wrong");
  cpf_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_CTRL && fault_evt_i.idx == 8'h26
    |=> trace_code_o == 16'h00a7)
    else $error("control error 38 code wrong");
  opt_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_OPT && fault_evt_i.idx == 8'h11
    |=> trace_code_o == 16'h0118 && group_code_o == 16'h0030)
    else $error("option abort code or group code wrong");
  unknown_a: assert property (fault_evt_i.valid && !rec && !frst_q
    |=> $stable(trace_code_o) && $stable(hist_o[0]))
    else $error("unlisted fault changed the trace");
  fault_wins_a: assert property (rec && frst_q |=>
    trace_code_o == $past(new_code))
    else $error("fault lost against a reset clear");
  clear_a: assert property (frst_q && !rec |=>
    trace_code_o == 16'h0000 && group_code_o == 16'h0000)
    else $error("fault reset did not clear the trace");
  hist_shift_a: assert property (rec |=>
    hist_o[1] == $past(hist_o[0]) && hist_o[3] == $past(hist_o[2]))
    else $error("history did not shift by one entry");
  oc2_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_FIXED && fault_evt_i.idx == 8'h07
    |=> trace_code_o == 16'h045f)
    else $error("second overcurrent code wrong");
  load_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_FIXED && fault_evt_i.idx == 8'h08
    |=> trace_code_o == 16'h000b)
    else $error("motor overload code wrong");
  ext_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_FIXED && fault_evt_i.idx == 8'h12
    |=> trace_code_o == 16'h0015)
    else $error("terminal seven external fault code wrong");
  link_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_FIXED && fault_evt_i.idx == 8'h19
    |=> trace_code_o == 16'h041b)
    else $error("second communication error code wrong");
  keypad_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_FIXED && fault_evt_i.idx == 8'h1e
    |=> trace_code_o == 16'h0415)
    else $error("comparator two limit code wrong");
  proto_code_a: assert property (fault_evt_i.valid &&
    fault_evt_i.grp == bcfm_pkg::GRP_OPT && fault_evt_i.idx == 8'h2b
    |=> trace_code_o == 16'h013e)
    else $error("receive timeout five code wrong");

  run_cov: cover property (op_hit && bcast_i.data[0] ##1 cmd_o.run);
  freq_cov: cover property (freq_hit ##1 freq_pct_o != 16'h0000);
  opt_cov: cover property (rec ##1 group_code_o == 16'h0030);
  clear_cov: cover property (frst_q && trace_code_o != 16'h0000
    ##1 trace_code_o == 16'h0000);

endmodule : bcfm_top

// ===== tb/bcfm_master.sv
// Partner model: fieldbus master issuing broadcast register writes.
// Assumes the bench calls send() from one process, on clock_i.
module bcfm_master (
  input  wire logic             clock_i,
  output bcfm_pkg::bcfm_bcast_t bcast_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Broadcast write
  // ----------------------------------------------------------------
  // Idle bus shows no valid word
  initial begin
    bcast_o = '0;
  end
  // One-cycle write; no answer is awaited
  task automatic send(input logic [15:0] reg_no, input logic [15:0] data);
    @(posedge clock_i);
    bcast_o <= '{valid: 1'b1, reg_no: reg_no, data: data};
    @(posedge clock_i);
    // Released lines carry inverted junk, not the last word
    bcast_o <= '{valid: 1'b0, reg_no: ~reg_no, data: ~data};
    #1;
  endtask : send
endmodule : bcfm_master

// ===== tb/bcfm_top_tb.sv
// Self-checking bench for the broadcast decoder and fault encoder.
// Assumes bcfm_top and bcfm_master are compiled before this file.
module bcfm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clock_i;
  logic                  rst_n_i;
  bcfm_pkg::bcfm_bcast_t bcast;
  logic [15:0]           local_op;
  bcfm_pkg::bcfm_evt_t   evt;
  bcfm_pkg::bcfm_cmd_t   cmd;
  logic [15:0]           op_word;
  logic                  fault_reset;
  logic [15:0]           freq_ref;
  logic [15:0]           freq_pct;
  logic [15:0]           trace;
  logic [15:0]           grp_code;
  logic [15:0]           hist [4];
  int                    failures;
  int                    compares;
  int                    cycles;
  // ----------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------
  bcfm_top i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .bcast_i(bcast),
    .local_op_i(local_op), .fault_evt_i(evt), .cmd_o(cmd),
    .op_word_o(op_word), .fault_reset_o(fault_reset), .freq_ref_o(freq_ref),
    .freq_pct_o(freq_pct), .trace_code_o(trace), .group_code_o(grp_code),
    .hist_o(hist));
  bcfm_master i_master (.clock_i(clock_i), .bcast_o(bcast));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle fault event from the detection logic
  task automatic fault(input logic [1:0] grp, input logic [7:0] idx);
    @(posedge clock_i);
    evt <= '{valid: 1'b1, grp: bcfm_pkg::bcfm_grp_t'(grp), idx: idx};
    @(posedge clock_i);
    evt <= '{valid: 1'b0, grp: bcfm_pkg::GRP_FIXED, idx: ~idx};
    #1;
  endtask : fault
  task automatic give_verdict();
    $display("Counts: compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Outputs after reset release
  task automatic test_reset();
    chk("op_word", 16'h0003, op_word);
    chk("fault_reset", 16'h0000, {15'h0, fault_reset});
    chk("trace", 16'h0000, trace);
    chk("freq_ref", 16'h0000, freq_ref);
    for (int i = 0; i < 4; i++) begin
      chk("hist", 16'h0000, hist[i]);
    end
    $display("test reset done");
  endtask : test_reset
  // Operation word with a given local signal
  task automatic test_op(input logic [15:0] data, input logic [15:0] loc,
                         input logic [15:0] word, input logic [5:0] c,
                         input logic frst);
    @(posedge clock_i);
    local_op <= loc;
    i_master.send(16'h0001, data);
    chk("op_word", word, op_word);
    chk("cmd", {10'h0, c}, {10'h0, cmd});
    chk("fault_reset", {15'h0, frst}, {15'h0, fault_reset});
    @(posedge clock_i);
    #1;
    chk("fault_reset end", 16'h0000, {15'h0, fault_reset});
    $display("test op %h done", data);
  endtask : test_op
  // Frequency reference scaling and an ignored register
  task automatic test_freq();
    i_master.send(16'h0002, 16'd30000);
    chk("freq_ref", 16'h7530, freq_ref);
    chk("freq_pct", 16'h2710, freq_pct);
    i_master.send(16'h0002, 16'd15000);
    chk("freq_pct", 16'h1388, freq_pct);
    i_master.send(16'h0003, 16'h1234);
    chk("freq_ref", 16'h3a98, freq_ref);
    chk("op_word", 16'h7033, op_word);
    $display("test freq done");
  endtask : test_freq
  // Fault code table: {group, index, code}
  task automatic test_faults();
    logic [27:0] tbl [22] = '{28'h0_00_0002, 28'h0_01_0003,
      28'h0_02_0004, 28'h0_03_0005, 28'h0_07_045f,
      28'h0_08_000b, 28'h0_0d_002a, 28'h0_0e_0011,
      28'h0_12_0015, 28'h0_14_0043, 28'h0_15_0027,
      28'h0_16_0021, 28'h0_19_041b, 28'h0_1a_0401,
      28'h0_1c_040f, 28'h0_1e_0415, 28'h1_02_0083,
      28'h1_26_00a7, 28'h2_00_0101, 28'h2_11_0118,
      28'h2_1e_0131, 28'h2_2b_013e};
    logic [15:0] prev;
    prev = 16'h0000;
    foreach (tbl[i]) begin
      fault(tbl[i][25:24], tbl[i][23:16]);
      chk("trace", tbl[i][15:0], trace);
      chk("group", (tbl[i][25:24] == 2'h2) ? 16'h0030 : 16'h0000,
          grp_code);
      chk("hist0", tbl[i][15:0], hist[0]);
      chk("hist1", prev, hist[1]);
      prev = tbl[i][15:0];
    end
    fault(2'h1, 8'h04);
    fault(2'h2, 8'h02);
    fault(2'h0, 8'h1f);
    fault(2'h0, 8'h20);
    chk("trace unlisted", 16'h013e, trace);
    chk("hist unlisted", 16'h0131, hist[1]);
    chk("hist2", 16'h0118, hist[2]);
    chk("hist3", 16'h0101, hist[3]);
    i_master.send(16'h0001, 16'h0020);
    @(posedge clock_i);
    #1;
    chk("trace cleared", 16'h0000, trace);
    chk("group cleared", 16'h0000, grp_code);
    chk("hist kept", 16'h013e, hist[0]);
    // Fault landing in the reset pulse cycle wins over the clear
    fork
      i_master.send(16'h0001, 16'h0020);
      begin
        @(posedge clock_i);
        fault(2'h0, 8'h05);
      end
    join
    chk("trace fault wins", 16'h0007, trace);
    chk("hist fault wins", 16'h013e, hist[1]);
    $display("test faults done");
  endtask : test_faults
  // ----------------------------------------------------------------
  // Clock, reset, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // Cycle ceiling well above the hundred or so the tests need
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    rst_n_i  = 1'b0;
    local_op = 16'h0003;
    evt      = '0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    test_reset();
    test_op(16'h0021, 16'hffff, 16'h8fed, 6'b100000, 1'b1);
    test_op(16'h7012, 16'h0000, 16'h7012, 6'b011111, 1'b0);
    test_op(16'h8fcc, 16'h0000, 16'h0000, 6'b000000, 1'b0);
    test_op(16'hffff, 16'h0000, 16'h7033, 6'b111111, 1'b1);
    test_freq();
    test_faults();
    give_verdict();
  end
endmodule : bcfm_top_tb
